// ---- rtl/srq_defines.svh ----
/*
  Bit positions, widths, reset values and command codes of the status-reporting block.
  Assumes inclusion by bare name from the design modules and the simulation files.
*/
`ifndef SRQ_DEFINES_SVH
`define SRQ_DEFINES_SVH

`define SRQ_SUM_QUAL_BIT 3
`define SRQ_SUM_MSG_BIT 4
`define SRQ_SUM_STD_BIT 5
`define SRQ_SUM_RQS_BIT 6
`define SRQ_SUM_OPER_BIT 7

`define SRQ_QUAL_OVER_BIT 0
`define SRQ_QUAL_CONV_BIT 8

`define SRQ_STD_OPC_BIT 0
`define SRQ_STD_QUERY_BIT 2
`define SRQ_STD_DEVDEP_BIT 3
`define SRQ_STD_EXEC_BIT 4
`define SRQ_STD_CMD_BIT 5
`define SRQ_STD_PON_BIT 7

`define SRQ_OPER_MEAS_BIT 4
`define SRQ_OPER_TRIGGER_WAIT_BIT 5
`define SRQ_OPER_ARM_BIT 6
`define SRQ_OPER_DATA_BIT 8
`define SRQ_OPER_BLOCK_BIT 9

`define SRQ_WIDE_USED 16'h7FFF
`define SRQ_QUAL_USED 16'h0101
`define SRQ_OPER_USED 16'h0370
`define SRQ_STD_USED 8'hBD
`define SRQ_SRE_USED 8'hBF
`define SRQ_STD_RESET 8'h80

`define SRQ_SEL_SUMMARY 4'h0
`define SRQ_SEL_SRE 4'h1
`define SRQ_SEL_STD_LATCH 4'h2
`define SRQ_SEL_STD_MASK 4'h3
`define SRQ_SEL_QUAL_COND 4'h4
`define SRQ_SEL_QUAL_EVENT 4'h5
`define SRQ_SEL_QUAL_MASK 4'h6
`define SRQ_SEL_OPER_COND 4'h7
`define SRQ_SEL_OPER_EVENT 4'h8
`define SRQ_SEL_OPER_MASK 4'h9

`endif

// ---- rtl/srq_pkg.sv ----
/*
  Types shared by the status-reporting block.
  Uses nothing from the defines header; state codes are literal.
*/
package srq_pkg;
  typedef enum logic [1:0] {
    SRQ_IDLE = 2'b00,
    SRQ_PEND = 2'b01
  } srq_state_type;
endpackage : srq_pkg

// ---- rtl/srq_event_if.sv ----
/*
  Interface carrying one 16-bit register set between the top and its event latch.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/100ps
interface srq_event_if;
  logic [15:0] cond;
  logic [15:0] event_bits;
  logic [15:0] mask;
  logic clear;
  logic summary;
  modport owner (output cond, output mask, output clear, input event_bits, input summary);
  modport latch (input cond, input mask, input clear, output event_bits, output summary);
endinterface : srq_event_if

// ---- rtl/srq_event_latch.sv ----
/*
  Event latch of one 16-bit register set: latches changed condition bits and forms the summary.
  Assumes cond is synchronous to clk and clear is a one-cycle pulse.
*/
`timescale 1ns/100ps
`include "srq_defines.svh"
module srq_event_latch (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register set.
  srq_event_if.latch regs
);
  typedef struct packed {
    logic [15:0] prevCond;
    logic [15:0] events;
  } srq_latch_type;

  srq_latch_type state;
  srq_latch_type next_state;

  always_comb begin
    next_state = state;
    next_state.prevCond = regs.cond;
    next_state.events = (regs.clear ? 16'h0000 : state.events)
      | ((regs.cond ^ state.prevCond) & `SRQ_WIDE_USED);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign regs.event_bits = state.events & `SRQ_WIDE_USED;
  assign regs.summary = |(state.events & regs.mask);
endmodule : srq_event_latch

// ---- rtl/srq_sync2.sv ----
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes inputs are asynchronous to clk.
*/
`timescale 1ns/100ps
module srq_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Data.
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } srq_sync_type;

  srq_sync_type state;
  srq_sync_type next_state;

  always_comb begin
    next_state.first = din;
    next_state.second = state.first;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dout = state.second;
endmodule : srq_sync2

// ---- rtl/srq_status.sv ----
/*
  Status-reporting block: summary byte, quality, standard event and operational sets,
  and service request generation with serial-poll clear.
  Assumes a command parser on clk that issues one-cycle strobes and reads; converter
  and measurement status arrive as asynchronous pin levels.
*/
`timescale 1ns/100ps
`include "srq_defines.svh"
// Function
// - Bit 3: enabled quality events present
// - Bit 4: output queue not empty
// - Bit 5: enabled standard events present
// - Status query bit 6 is master summary
// - Serial poll bit 6 is request flag
// - Bit 7: enabled operational events present
// - Quality bit 0: converter over range
// - Quality bit 8: converter hardware error
// - Standard set: latch, mask; bit0 operation-complete
// - Bits 2-5 from parser errors
// - Bit 7 set at power on
// - Operational bit 4 while measuring
// - Bit 5 ready for trigger; gate triggers
// - Bit 6 while engine idle awaiting arm
// - Bits 8, 9: data, block ready
// - Clear-status zeroes events, empties errors, keeps masks
// - Standard mask written and read weighted
// - Reading standard latch returns then clears
// - Standard bits stick until read or clear
// - Event bits latch on any condition change
// - Wide registers 16 bits, bit 15 zero
// - Request starts on enabled rise, not pending
// - Serial poll clears request, keeps others
module srq_status (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Converter and measurement pin levels.
  input wire logic overRange,
  input wire logic convError,
  input wire logic measuring,
  input wire logic engineIdle,
  input wire logic armedForTrigger,
  input wire logic dataReady,
  input wire logic blockReady,
  // Trigger in and gated trigger out.
  input wire logic triggerIn,
  output logic triggerAccepted,
  // Parser event strobes.
  input wire logic opcCmd,
  input wire logic queryError,
  input wire logic devDepError,
  input wire logic execError,
  input wire logic cmdError,
  input wire logic clearStatus,
  // Output queue state.
  input wire logic outQueueNotEmpty,
  output logic errorQueueFlush,
  // Register access from the parser.
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [3:0] regSel,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  // Serial poll and service request line.
  input wire logic serialPoll,
  output logic [7:0] pollByte,
  output logic serviceRequest
);
  typedef struct packed {
    srq_pkg::srq_state_type srqState;
    logic [7:0] stdLatch;
    logic [7:0] stdMask;
    logic [7:0] sreMask;
    logic [15:0] qualMask;
    logic [15:0] operMask;
    logic [7:0] prevSummary;
    logic [15:0] rdata;
    logic [7:0] poll;
    logic flush;
    logic trigOut;
  } srq_top_type;

  srq_top_type state;
  srq_top_type next_state;

  logic [6:0] pins;
  logic [7:0] summary;
  logic masterSummary;
  logic [7:0] stdSet;

  srq_event_if qualIf ();
  srq_event_if operIf ();

  srq_sync2 #(.WIDTH(7)) pinSync (
    .clk(clk),
    .rst(rst),
    .din({blockReady, dataReady, engineIdle, armedForTrigger, measuring, convError, overRange}),
    .dout(pins)
  );

  srq_event_latch qualLatch (
    .clk(clk),
    .rst(rst),
    .regs(qualIf.latch)
  );

  srq_event_latch operLatch (
    .clk(clk),
    .rst(rst),
    .regs(operIf.latch)
  );

  always_comb begin
    qualIf.cond = 16'h0000;
    qualIf.cond[`SRQ_QUAL_OVER_BIT] = pins[0];
    qualIf.cond[`SRQ_QUAL_CONV_BIT] = pins[1];
    operIf.cond = 16'h0000;
    operIf.cond[`SRQ_OPER_MEAS_BIT] = pins[2];
    operIf.cond[`SRQ_OPER_TRIGGER_WAIT_BIT] = pins[3];
    operIf.cond[`SRQ_OPER_ARM_BIT] = pins[4];
    operIf.cond[`SRQ_OPER_DATA_BIT] = pins[5];
    operIf.cond[`SRQ_OPER_BLOCK_BIT] = pins[6];
  end

  assign qualIf.mask = state.qualMask;
  assign operIf.mask = state.operMask;
  assign qualIf.clear = clearStatus;
  assign operIf.clear = clearStatus;

  always_comb begin
    summary = 8'h00;
    summary[`SRQ_SUM_QUAL_BIT] = qualIf.summary;
    summary[`SRQ_SUM_MSG_BIT] = outQueueNotEmpty;
    summary[`SRQ_SUM_STD_BIT] = |(state.stdLatch & state.stdMask);
    summary[`SRQ_SUM_OPER_BIT] = operIf.summary;
    masterSummary = |(summary & state.sreMask);
  end

  always_comb begin
    stdSet = 8'h00;
    stdSet[`SRQ_STD_OPC_BIT] = opcCmd;
    stdSet[`SRQ_STD_QUERY_BIT] = queryError;
    stdSet[`SRQ_STD_DEVDEP_BIT] = devDepError;
    stdSet[`SRQ_STD_EXEC_BIT] = execError;
    stdSet[`SRQ_STD_CMD_BIT] = cmdError;
  end

  always_comb begin
    next_state = state;
    next_state.prevSummary = summary;
    next_state.flush = clearStatus;
    next_state.trigOut = triggerIn & pins[3];
    next_state.rdata = 16'h0000;
    if (clearStatus) begin
      next_state.stdLatch = 8'h00;
    end
    if (regRead) begin
      case (regSel)
        `SRQ_SEL_SUMMARY: next_state.rdata = {8'h00, summary | {1'b0, masterSummary, 6'h00}};
        `SRQ_SEL_SRE: next_state.rdata = {8'h00, state.sreMask};
        `SRQ_SEL_STD_LATCH: begin
          next_state.rdata = {8'h00, state.stdLatch};
          next_state.stdLatch = 8'h00;
        end
        `SRQ_SEL_STD_MASK: next_state.rdata = {8'h00, state.stdMask};
        `SRQ_SEL_QUAL_COND: next_state.rdata = qualIf.cond;
        `SRQ_SEL_QUAL_EVENT: next_state.rdata = qualIf.event_bits;
        `SRQ_SEL_QUAL_MASK: next_state.rdata = state.qualMask;
        `SRQ_SEL_OPER_COND: next_state.rdata = operIf.cond;
        `SRQ_SEL_OPER_EVENT: next_state.rdata = operIf.event_bits;
        `SRQ_SEL_OPER_MASK: next_state.rdata = state.operMask;
        default: next_state.rdata = 16'h0000;
      endcase
    end
    next_state.stdLatch = next_state.stdLatch | stdSet;
    if (regWrite) begin
      case (regSel)
        `SRQ_SEL_SRE: next_state.sreMask = regWdata[7:0] & `SRQ_SRE_USED;
        `SRQ_SEL_STD_MASK: next_state.stdMask = regWdata[7:0];
        `SRQ_SEL_QUAL_MASK: next_state.qualMask = regWdata & `SRQ_WIDE_USED;
        `SRQ_SEL_OPER_MASK: next_state.operMask = regWdata & `SRQ_WIDE_USED;
        default: next_state.sreMask = state.sreMask;
      endcase
    end
    next_state.poll = 8'h00;
    if (serialPoll) begin
      next_state.poll = summary | {1'b0, state.srqState == srq_pkg::SRQ_PEND, 6'h00};
    end
    case (state.srqState)
      srq_pkg::SRQ_IDLE: begin
        if (|(summary & ~state.prevSummary & state.sreMask)) begin
          next_state.srqState = srq_pkg::SRQ_PEND;
        end
      end
      srq_pkg::SRQ_PEND: begin
        if (serialPoll) begin
          next_state.srqState = srq_pkg::SRQ_IDLE;
        end
      end
      default: next_state.srqState = srq_pkg::SRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
      state.stdLatch <= `SRQ_STD_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign regRdata = state.rdata;
  assign pollByte = state.poll;
  assign serviceRequest = (state.srqState == srq_pkg::SRQ_PEND);
  assign errorQueueFlush = state.flush;
  assign triggerAccepted = state.trigOut;
endmodule : srq_status

// ---- sim/srq_status_chk.sv ----
/* Port assertions of the status block.
   Assumes it is bound onto srq_status and shares its clock and reset. */
`timescale 1ns/100ps
`include "srq_defines.svh"
module srq_status_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Watched ports.
  input wire logic armedForTrigger,
  input wire logic triggerIn,
  input wire logic triggerAccepted,
  input wire logic clearStatus,
  input wire logic errorQueueFlush,
  input wire logic outQueueNotEmpty,
  input wire logic regRead,
  input wire logic [3:0] regSel,
  input wire logic [15:0] regRdata,
  input wire logic serialPoll,
  input wire logic [7:0] pollByte,
  input wire logic serviceRequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_flush; clearStatus |=> errorQueueFlush; endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_trigger_wait; (!armedForTrigger [*4] ##0 triggerIn) |=> !triggerAccepted; endproperty
  a_trigger_wait: assert property (p_trigger_wait) else $error("trigger taken");
  property p_msg; regRead && regSel == `SRQ_SEL_SUMMARY |=> regRdata[4] == $past(outQueueNotEmpty); endproperty
  a_msg: assert property (p_msg) else $error("bad bit 4");
  property p_rqs; serialPoll |=> pollByte[6] == $past(serviceRequest); endproperty
  a_rqs: assert property (p_rqs) else $error("bad poll bit 6");
  property p_pclr; serialPoll |=> !serviceRequest; endproperty
  a_pclr: assert property (p_pclr) else $error("request kept");
  property p_hold; serviceRequest && !serialPoll |=> serviceRequest; endproperty
  a_hold: assert property (p_hold) else $error("request lost");
  property p_wide; regRead |=> !regRdata[15]; endproperty
  a_wide: assert property (p_wide) else $error("bit 15 set");
  property p_byte; regRead && regSel < 4'h4 |=> regRdata[15:8] == 8'h00; endproperty
  a_byte: assert property (p_byte) else $error("upper byte set");
endmodule : srq_status_chk
bind srq_status srq_status_chk u_chk (.clk(clk), .rst(rst), .armedForTrigger(armedForTrigger),
  .triggerIn(triggerIn), .triggerAccepted(triggerAccepted), .clearStatus(clearStatus),
  .errorQueueFlush(errorQueueFlush), .outQueueNotEmpty(outQueueNotEmpty), .regRead(regRead),
  .regSel(regSel), .regRdata(regRdata), .serialPoll(serialPoll), .pollByte(pollByte),
  .serviceRequest(serviceRequest));

// ---- sim/srq_ctrl_model.sv ----
/* Bus controller model: register writes and reads, serial polls, clear-status.
   Assumes the bench calls its tasks; all changes happen at the falling edge. */
`timescale 1ns/100ps
module srq_ctrl_model (
  // Clock.
  input wire logic clk,
  // Register access.
  output logic regWrite,
  output logic regRead,
  output logic [3:0] regSel,
  output logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  // Poll and clear.
  input wire logic [7:0] pollByte,
  output logic serialPoll,
  output logic clearStatus
);
  initial begin
    {regWrite, regRead, serialPoll, clearStatus, regSel, regWdata} = '0;
  end
  task automatic wr(input logic [3:0] s, input logic [15:0] v);
    @(negedge clk);
    {regSel, regWdata, regWrite} = {s, v, 1'b1};
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~v;
  endtask : wr
  task automatic rd(input logic [3:0] s, output logic [15:0] v);
    @(negedge clk);
    {regSel, regRead} = {s, 1'b1};
    @(negedge clk);
    regRead = 1'b0;
    v = regRdata;
  endtask : rd
  task automatic poll(output logic [7:0] v);
    @(negedge clk);
    serialPoll = 1'b1;
    @(negedge clk);
    serialPoll = 1'b0;
    v = pollByte;
  endtask : poll
  task automatic cls();
    @(negedge clk);
    clearStatus = 1'b1;
    @(negedge clk);
    clearStatus = 1'b0;
  endtask : cls
endmodule : srq_ctrl_model

// ---- sim/tb_top.sv ----
/* Self-checking bench of the status block.
   Assumes the controller model issues register access, polls and clear-status. */
`timescale 1ns/100ps
`include "srq_defines.svh"
module tb_top;
  logic clk, rst, ovr, cerr, meas, idle, arm, dat, blk, trg, trgAcc, mq, flush, rw, rr, sp, cls, srq;
  logic [4:0] ev;
  logic [3:0] sel;
  logic [15:0] wd, rdat, d;
  logic [7:0] pb, b;
  int miscompares, checks;
  srq_status DUT (.clk(clk), .rst(rst), .overRange(ovr), .convError(cerr), .measuring(meas),
    .engineIdle(idle), .armedForTrigger(arm), .dataReady(dat), .blockReady(blk), .triggerIn(trg),
    .triggerAccepted(trgAcc), .opcCmd(ev[0]), .queryError(ev[1]), .devDepError(ev[2]),
    .execError(ev[3]), .cmdError(ev[4]), .clearStatus(cls), .outQueueNotEmpty(mq),
    .errorQueueFlush(flush), .regWrite(rw), .regRead(rr), .regSel(sel), .regWdata(wd),
    .regRdata(rdat), .serialPoll(sp), .pollByte(pb), .serviceRequest(srq));
  srq_ctrl_model u_ctrl (.clk(clk), .regWrite(rw), .regRead(rr), .regSel(sel), .regWdata(wd),
    .regRdata(rdat), .pollByte(pb), .serialPoll(sp), .clearStatus(cls));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [4:0] v);
    @(negedge clk);
    ev = v;
    @(negedge clk);
    ev = 5'h00;
  endtask : pulse
  task automatic t_power();
    u_ctrl.rd(`SRQ_SEL_STD_LATCH, d);
    chk(d, 16'h0080);
    u_ctrl.rd(`SRQ_SEL_STD_LATCH, d);
    chk(d, 16'h0000);
    u_ctrl.rd(4'hF, d);
    chk(d, 16'h0000);
    pulse(5'h00);
    trg = 1'b1;
    @(negedge clk);
    trg = 1'b0;
    chk({15'h0000, trgAcc}, 16'h0000);
    $display("t_power done");
  endtask : t_power
  task automatic t_srq();
    u_ctrl.wr(`SRQ_SEL_STD_MASK, 16'h00BD);
    u_ctrl.rd(`SRQ_SEL_STD_MASK, d);
    chk(d, 16'h00BD);
    u_ctrl.wr(`SRQ_SEL_SRE, 16'h0060);
    u_ctrl.rd(`SRQ_SEL_SRE, d);
    chk(d, 16'h0020);
    pulse(5'h10);
    for (int i = 0; i < 8 && srq !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk({15'h0000, srq}, 16'h0001);
    u_ctrl.poll(b);
    chk({8'h00, b}, 16'h0060);
    u_ctrl.poll(b);
    chk({8'h00, b}, 16'h0020);
    mq = 1'b1;
    u_ctrl.rd(`SRQ_SEL_SUMMARY, d);
    chk(d, 16'h0070);
    mq = 1'b0;
    $display("t_srq done");
  endtask : t_srq
  task automatic t_errs();
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
    end
    u_ctrl.rd(`SRQ_SEL_STD_LATCH, d);
    chk(d, 16'h003D);
    $display("t_errs done");
  endtask : t_errs
  task automatic t_pins();
    {ovr, cerr} = 2'b11;
    repeat (4) @(negedge clk);
    u_ctrl.rd(`SRQ_SEL_QUAL_COND, d);
    chk(d, 16'h0101);
    {ovr, cerr} = 2'b00;
    repeat (4) @(negedge clk);
    u_ctrl.rd(`SRQ_SEL_QUAL_EVENT, d);
    chk(d, 16'h0101);
    u_ctrl.wr(`SRQ_SEL_SRE, 16'h0028);
    u_ctrl.wr(`SRQ_SEL_QUAL_MASK, 16'h0101);
    repeat (3) @(negedge clk);
    u_ctrl.poll(b);
    chk({8'h00, b}, 16'h0048);
    u_ctrl.rd(`SRQ_SEL_SUMMARY, d);
    chk(d, 16'h0048);
    u_ctrl.cls();
    u_ctrl.rd(`SRQ_SEL_QUAL_EVENT, d);
    chk(d, 16'h0000);
    u_ctrl.rd(`SRQ_SEL_QUAL_MASK, d);
    chk(d, 16'h0101);
    $display("t_pins done");
  endtask : t_pins
  task automatic t_oper();
    {meas, idle, arm, dat, blk} = 5'h1F;
    repeat (4) @(negedge clk);
    u_ctrl.rd(`SRQ_SEL_OPER_COND, d);
    chk(d, 16'h0370);
    trg = 1'b1;
    @(negedge clk);
    trg = 1'b0;
    chk({15'h0000, trgAcc}, 16'h0001);
    u_ctrl.wr(`SRQ_SEL_OPER_MASK, 16'h0370);
    u_ctrl.rd(`SRQ_SEL_SUMMARY, d);
    chk(d, 16'h0080);
    u_ctrl.cls();
    u_ctrl.rd(`SRQ_SEL_OPER_EVENT, d);
    chk(d, 16'h0000);
    {meas, idle, arm, dat, blk} = 5'h00;
    repeat (4) @(negedge clk);
    u_ctrl.rd(`SRQ_SEL_OPER_EVENT, d);
    chk(d, 16'h0370);
    u_ctrl.rd(`SRQ_SEL_OPER_MASK, d);
    chk(d, 16'h0370);
    $display("t_oper done");
  endtask : t_oper
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
  initial begin
    {rst, ovr, cerr, meas, idle, arm, dat, blk, trg, mq, ev} = {10'h200, 5'h00};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_power();
    t_srq();
    t_errs();
    t_pins();
    t_oper();
    test_done();
  end
endmodule : tb_top
